// [core/vids_pkg.sv]
package vids_pkg;
    // Register byte offsets on the APB bus.
    localparam logic [7:0] VIDS_OFS_CTRL = 8'h00;
    localparam logic [7:0] VIDS_OFS_STATUS = 8'h04;
    localparam logic [7:0] VIDS_OFS_SEL = 8'h08;
    localparam logic [7:0] VIDS_OFS_CHCFG = 8'h0C;
    localparam logic [7:0] VIDS_OFS_WMIN = 8'h10;
    localparam logic [7:0] VIDS_OFS_WMAX = 8'h14;
    localparam logic [7:0] VIDS_OFS_RMIN = 8'h18;
    localparam logic [7:0] VIDS_OFS_RMAX = 8'h1C;
    localparam logic [7:0] VIDS_OFS_RAW = 8'h20;
    localparam logic [7:0] VIDS_OFS_SCALED = 8'h24;
    localparam logic [7:0] VIDS_OFS_IRQ_STAT = 8'h28;
    localparam logic [7:0] VIDS_OFS_IRQ_EN = 8'h2C;
    localparam logic [7:0] VIDS_OFS_IRQ_CLR = 8'h30;

    // Control register fields.
    localparam int VIDS_CTRL_COUNT_LSB = 0;
    localparam int VIDS_CTRL_COMMIT_BIT = 8;
    localparam logic [4:0] VIDS_COUNT_RESET = 5'h10;
    localparam int VIDS_CHANNELS = 16;

    // Health byte bit positions.
    localparam int VIDS_HEALTH_SELFTEST_BIT = 0;
    localparam int VIDS_HEALTH_SUPPLY_BIT = 1;
    localparam int VIDS_HEALTH_INVALID_BIT = 2;

    // Channel configuration fields.
    localparam int VIDS_CFG_RANGE_LSB = 0;
    localparam int VIDS_CFG_U16_BIT = 2;
    localparam int VIDS_CFG_SCALE_BIT = 3;
    localparam int VIDS_CFG_CLAMP_BIT = 4;
    localparam int VIDS_CFG_WEIGHT_LSB = 16;

    // Interrupt status bits.
    localparam int VIDS_IRQ_SELFTEST_BIT = 0;
    localparam int VIDS_IRQ_SUPPLY_BIT = 1;
    localparam int VIDS_IRQ_RANGE_BIT = 2;
    localparam int VIDS_IRQ_SCAN_BIT = 3;

    typedef enum logic [1:0] {
        VIDS_RANGE_U10 = 2'h0,
        VIDS_RANGE_U5 = 2'h1,
        VIDS_RANGE_B10 = 2'h2,
        VIDS_RANGE_B5 = 2'h3
    } vids_range_type;

    localparam vids_range_type VIDS_RANGE_RESET = VIDS_RANGE_U10;
    localparam logic [15:0] VIDS_SIGN_FLIP = 16'h8000;

    // Count weights in microvolts.
    localparam logic [15:0] VIDS_UV_305 = 16'h0131;
    localparam logic [15:0] VIDS_UV_152 = 16'h0098;
    localparam logic [15:0] VIDS_UV_76 = 16'h004C;

    typedef enum logic [1:0] {
        VIDS_ST_START = 2'b01,
        VIDS_ST_WAIT = 2'b10
    } vids_state_type;
endpackage

// [core/vids_core.sv]
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Unipolar ranges give counts 0..32767, or 0..65535 when the unsigned 16-bit option is set.
// - Bipolar ranges give signed 16-bit two's complement counts from -32768 to 32767.
// - The status image is 24 contiguous bits, byte aligned.
// - Status byte 0 holds self-test failed at bit 0, supply missing at bit 1, data invalid at bit 2.
// - The self-test flag is on whenever the self-test has not passed.
// - The supply flag is on while the external field supply is absent.
// - The invalid flag is on until a configuration is committed and after any later change.
// - Byte 1 holds channels 1 to 8 out-of-range flags, byte 2 channels 9 to 16, channel 1 at the LSB.
// - A channel's out-of-range flag is on while its input is outside its selected range.
// - Only the configured number of channels (1 to 16) is converted; all 16 by default and when the count is 0 or above 16.
// - Each channel selects 0-10 V, 0-5 V, +/-10 V or +/-5 V independently.
// - The count weight follows range and resolution: 305, 152 or 76 microvolts.
// - With scaling on, raw min and max map linearly onto engineering min and max.
// - With scaling and clamping both on, the scaled value is held inside the engineering min and max.
module vids_core
    import vids_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic conv_start,
    output logic [3:0] conv_chan,
    output logic [1:0] conv_range,
    input wire logic conv_done,
    input wire logic [15:0] conv_code,
    input wire logic conv_over,
    input wire logic selftest_ok,
    input wire logic supply_ok,
    output logic [23:0] status_image,
    output logic irq
);
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        vids_state_type state;
        logic conv_start;
        logic [3:0] chan;
        logic [1:0] conv_range;
        logic [4:0] count;
        logic valid;
        logic [3:0] sel;
        logic [15:0][4:0] cfg;
        logic [15:0][31:0] wmin;
        logic [15:0][31:0] wmax;
        logic [15:0][31:0] rmin;
        logic [15:0][31:0] rmax;
        logic [15:0][15:0] raw;
        logic [15:0][31:0] scaled;
        logic [15:0] over;
        logic [23:0] status;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic irq;
    } vids_regs_type;

    vids_regs_type r;
    vids_regs_type next_r;

    // Converter code is offset binary across the selected span: 0 is the bottom of the range.
    function automatic logic [15:0] fmt_raw(input logic [1:0] rng, input logic u16,
                                            input logic [15:0] code);
        if (rng[1]) begin
            fmt_raw = code ^ VIDS_SIGN_FLIP;
        end else if (u16) begin
            fmt_raw = code;
        end else begin
            fmt_raw = {1'b0, code[15:1]};
        end
    endfunction

    // Raw word widened to a signed integer as the controller would interpret it.
    function automatic logic signed [31:0] raw_int(input logic [4:0] cfg, input logic [15:0] w);
        if (cfg[1] == 1'b1) begin
            raw_int = {{16{w[15]}}, w};
        end else begin
            raw_int = {16'h0000, w};
        end
    endfunction

    function automatic logic [15:0] weight_uv(input logic [4:0] cfg);
        case (cfg[1:0])
            VIDS_RANGE_U10: weight_uv = cfg[VIDS_CFG_U16_BIT] ? VIDS_UV_152 : VIDS_UV_305;
            VIDS_RANGE_U5: weight_uv = cfg[VIDS_CFG_U16_BIT] ? VIDS_UV_76 : VIDS_UV_152;
            VIDS_RANGE_B10: weight_uv = VIDS_UV_305;
            default: weight_uv = VIDS_UV_152;
        endcase
    endfunction

    logic [4:0] ccfg;
    logic [15:0] new_raw;
    logic signed [31:0] x;
    logic signed [31:0] wlo;
    logic signed [31:0] whi;
    logic signed [31:0] elo;
    logic signed [31:0] ehi;
    logic signed [63:0] num;
    logic signed [63:0] den;
    logic signed [63:0] quo;
    logic signed [31:0] val;
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic [4:0] last_chan;

    // One shared scaler serves the single multiplexed converter, trading speed for area.
    always_comb begin
        ccfg = r.cfg[r.chan];
        new_raw = fmt_raw(ccfg[1:0], ccfg[VIDS_CFG_U16_BIT], conv_code);
        x = raw_int(ccfg, new_raw);
        wlo = r.wmin[r.chan];
        whi = r.wmax[r.chan];
        elo = r.rmin[r.chan];
        ehi = r.rmax[r.chan];
        num = 64'(x - wlo) * 64'(ehi - elo);
        den = 64'(whi) - 64'(wlo);
        if (den == 64'sh0) begin
            quo = 64'sh0;
        end else begin
            quo = num / den;
        end
        val = ccfg[VIDS_CFG_SCALE_BIT] ? elo + quo[31:0] : x;
        lo = (elo < ehi) ? elo : ehi;
        hi = (elo < ehi) ? ehi : elo;
        if (ccfg[VIDS_CFG_SCALE_BIT] && ccfg[VIDS_CFG_CLAMP_BIT]) begin
            if (val < lo) begin
                val = lo;
            end else if (val > hi) begin
                val = hi;
            end
        end
        last_chan = (r.count == 5'h00 || r.count > VIDS_COUNT_RESET) ? 5'h0F : r.count - 5'h01;
    end

    logic acc;
    logic wr;
    logic hit;
    logic [31:0] rd;
    logic cfg_change;
    logic [3:0] ev;
    logic [4:0] rcfg;

    always_comb begin
        next_r = r;
        acc = psel && penable && !r.pready;
        wr = psel && penable && r.pready && pwrite;
        rcfg = r.cfg[r.sel];
        hit = 1'b1;
        rd = 32'h0000_0000;
        case (paddr)
            VIDS_OFS_CTRL: rd = {23'h0, r.valid, 3'h0, r.count};
            VIDS_OFS_STATUS: rd = {8'h00, r.status};
            VIDS_OFS_SEL: rd = {28'h0, r.sel};
            VIDS_OFS_CHCFG: rd = {weight_uv(rcfg), 11'h0, rcfg};
            VIDS_OFS_WMIN: rd = r.wmin[r.sel];
            VIDS_OFS_WMAX: rd = r.wmax[r.sel];
            VIDS_OFS_RMIN: rd = r.rmin[r.sel];
            VIDS_OFS_RMAX: rd = r.rmax[r.sel];
            VIDS_OFS_RAW: rd = {16'h0000, r.raw[r.sel]};
            VIDS_OFS_SCALED: rd = r.scaled[r.sel];
            VIDS_OFS_IRQ_STAT: rd = {28'h0, r.irq_stat};
            VIDS_OFS_IRQ_EN: rd = {28'h0, r.irq_en};
            VIDS_OFS_IRQ_CLR: rd = 32'h0000_0000;
            default: hit = 1'b0;
        endcase
        // Access phase takes two cycles: data is set up, then pready is presented.
        next_r.pready = acc;
        if (acc) begin
            next_r.prdata = pwrite ? 32'h0000_0000 : rd;
            next_r.pslverr = !hit;
        end else begin
            next_r.prdata = 32'h0000_0000;
            next_r.pslverr = 1'b0;
        end

        cfg_change = 1'b0;
        if (wr) begin
            case (paddr)
                VIDS_OFS_CTRL: begin
                    next_r.count = pwdata[VIDS_CTRL_COUNT_LSB +: 5];
                    cfg_change = (pwdata[VIDS_CTRL_COUNT_LSB +: 5] != r.count);
                end
                VIDS_OFS_SEL: next_r.sel = pwdata[3:0];
                VIDS_OFS_CHCFG: begin
                    next_r.cfg[r.sel] = pwdata[4:0];
                    cfg_change = 1'b1;
                end
                VIDS_OFS_WMIN: begin
                    next_r.wmin[r.sel] = pwdata;
                    cfg_change = 1'b1;
                end
                VIDS_OFS_WMAX: begin
                    next_r.wmax[r.sel] = pwdata;
                    cfg_change = 1'b1;
                end
                VIDS_OFS_RMIN: begin
                    next_r.rmin[r.sel] = pwdata;
                    cfg_change = 1'b1;
                end
                VIDS_OFS_RMAX: begin
                    next_r.rmax[r.sel] = pwdata;
                    cfg_change = 1'b1;
                end
                VIDS_OFS_IRQ_EN: next_r.irq_en = pwdata[3:0];
                default: cfg_change = 1'b0;
            endcase
        end
        // A stale configuration invalidates the data until software commits again.
        if (cfg_change) begin
            next_r.valid = 1'b0;
        end else if (wr && paddr == VIDS_OFS_CTRL && pwdata[VIDS_CTRL_COMMIT_BIT]) begin
            next_r.valid = 1'b1;
        end

        ev = 4'h0;
        next_r.conv_start = 1'b0;
        case (r.state)
            VIDS_ST_START: begin
                next_r.conv_start = 1'b1;
                next_r.state = VIDS_ST_WAIT;
            end
            VIDS_ST_WAIT: begin
                if (conv_done) begin
                    next_r.raw[r.chan] = new_raw;
                    next_r.scaled[r.chan] = val;
                    next_r.over[r.chan] = conv_over;
                    ev[VIDS_IRQ_RANGE_BIT] = conv_over && !r.over[r.chan];
                    if ({1'b0, r.chan} >= last_chan) begin
                        next_r.chan = 4'h0;
                        ev[VIDS_IRQ_SCAN_BIT] = 1'b1;
                    end else begin
                        next_r.chan = r.chan + 4'h1;
                    end
                    next_r.state = VIDS_ST_START;
                end
            end
            default: next_r.state = VIDS_ST_START;
        endcase
        // Channels beyond the enabled count are not measured, so they cannot be out of range.
        for (int i = 0; i < VIDS_CHANNELS; i++) begin
            if (5'(i) > last_chan) begin
                next_r.over[i] = 1'b0;
            end
        end

        // The range goes out from its own flop so the converter never sees a decode glitch.
        next_r.conv_range = next_r.cfg[next_r.chan][1:0];

        next_r.status = 24'h00_0000;
        next_r.status[VIDS_HEALTH_SELFTEST_BIT] = !selftest_ok;
        next_r.status[VIDS_HEALTH_SUPPLY_BIT] = !supply_ok;
        next_r.status[VIDS_HEALTH_INVALID_BIT] = !r.valid;
        next_r.status[23:8] = r.over;

        ev[VIDS_IRQ_SELFTEST_BIT] = !selftest_ok && !r.status[VIDS_HEALTH_SELFTEST_BIT];
        ev[VIDS_IRQ_SUPPLY_BIT] = !supply_ok && !r.status[VIDS_HEALTH_SUPPLY_BIT];
        // A new event in the same cycle as its clear keeps the bit set.
        if (wr && paddr == VIDS_OFS_IRQ_CLR) begin
            next_r.irq_stat = (r.irq_stat & ~pwdata[3:0]) | ev;
        end else begin
            next_r.irq_stat = r.irq_stat | ev;
        end
        next_r.irq = |(next_r.irq_stat & next_r.irq_en);
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.state <= VIDS_ST_START;
            r.count <= VIDS_COUNT_RESET;
            r.conv_range <= VIDS_RANGE_RESET;
            r.cfg <= {VIDS_CHANNELS{3'h0, VIDS_RANGE_RESET}};
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign conv_start = r.conv_start;
    assign conv_chan = r.chan;
    assign conv_range = r.conv_range;
    assign status_image = r.status;
    assign irq = r.irq;
endmodule
`default_nettype wire

// [tb/vids_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module vids_chk
    import vids_pkg::*;
(
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic conv_start,
    input wire logic [3:0] conv_chan,
    input wire logic conv_done,
    input wire logic conv_over,
    input wire logic selftest_ok,
    input wire logic supply_ok,
    input wire logic [23:0] status_image
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    sequence s_cfg_write;
        psel && penable && pready && pwrite && paddr == VIDS_OFS_CHCFG;
    endsequence
    sequence s_result;
        conv_done ##2 1'b1;
    endsequence
    a_selftest_flag: assert property ($past(nrst) |-> status_image[0] == !$past(selftest_ok))
        else $error("self-test flag wrong");
    a_supply_flag: assert property ($past(nrst) |-> status_image[1] == !$past(supply_ok))
        else $error("supply flag wrong");
    a_unused_bits: assert property (status_image[7:3] == 5'h00)
        else $error("unused health bits set");
    a_invalid_on_cfg: assert property (s_cfg_write |-> ##2 status_image[2])
        else $error("invalid flag not raised");
    a_range_flag: assert property (s_result |-> status_image[8 + $past(conv_chan, 2)] == $past(conv_over, 2))
        else $error("range flag wrong");
    a_scan_next: assert property (s_result |-> conv_start)
        else $error("next conversion late");
    a_chan_steady: assert property ($past(nrst) && !$past(conv_done) |-> $stable(conv_chan))
        else $error("channel moved early");
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start not a pulse");
endmodule
bind vids_core vids_chk i_chk (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .conv_start(conv_start),
    .conv_chan(conv_chan), .conv_done(conv_done), .conv_over(conv_over),
    .selftest_ok(selftest_ok), .supply_ok(supply_ok), .status_image(status_image));
`default_nettype wire

// [tb/vids_conv_model.sv]
`timescale 1ns/1ps
`default_nettype none
module vids_conv_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic conv_start,
    input wire logic [3:0] conv_chan,
    input wire logic slow,
    input wire logic [3:0] over_chan,
    input wire logic over_req,
    output logic conv_done,
    output logic [15:0] conv_code,
    output logic conv_over
);
    logic busy;
    logic [3:0] cnt;
    // Outside a result the lines toggle, so a late sample never sees a stale code.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            conv_done <= 1'b0;
            conv_code <= 16'h0000;
            conv_over <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            conv_code <= ~conv_code;
            conv_over <= ~conv_over;
            if (conv_start) begin
                busy <= 1'b1;
                cnt <= slow ? 4'hC : 4'h2;
            end else if (busy && cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end else if (busy) begin
                busy <= 1'b0;
                conv_done <= 1'b1;
                conv_code <= 16'h1234;
                conv_over <= over_req && conv_chan == over_chan;
            end
        end
    end
endmodule
`default_nettype wire

// [tb/test_vids_core.sv]
`timescale 1ns/1ps
`default_nettype none
module test_vids_core
    import vids_pkg::*;
;
    logic core_clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, conv_start, conv_done, conv_over, irq, err;
    logic selftest_ok = 1'b1, supply_ok = 1'b1, slow = 1'b0, over_req = 1'b0;
    logic [3:0] conv_chan, over_chan = 4'h0;
    logic [1:0] conv_range;
    logic [15:0] conv_code;
    logic [23:0] status_image;
    logic [15:0] w_t[6] = '{16'h0131, 16'h0098, 16'h0131, 16'h0098, 16'h0098, 16'h004C};
    logic [15:0] r_t[6] = '{16'h091A, 16'h091A, 16'h9234, 16'h9234, 16'h1234, 16'h1234};
    int n_errors = 0, n_compared = 0;
    always #20 core_clk = ~core_clk;
    vids_core i_dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .conv_start(conv_start), .conv_chan(conv_chan),
        .conv_range(conv_range), .conv_done(conv_done), .conv_code(conv_code),
        .conv_over(conv_over), .selftest_ok(selftest_ok), .supply_ok(supply_ok),
        .status_image(status_image), .irq(irq));
    vids_conv_model i_conv (.core_clk(core_clk), .nrst(nrst), .conv_start(conv_start),
        .conv_chan(conv_chan), .slow(slow), .over_chan(over_chan), .over_req(over_req),
        .conv_done(conv_done), .conv_code(conv_code), .conv_over(conv_over));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic wait_conv(input int n);
        repeat (n) do @(posedge core_clk); while (conv_done !== 1'b1);
        repeat (3) @(posedge core_clk);
    endtask
    task automatic stop_test;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        stop_test();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rchk(VIDS_OFS_STATUS, 32'h0000_0004);
        rchk(VIDS_OFS_CTRL, 32'h0000_0010);
        wr(VIDS_OFS_SEL, 32'h0);
        // Shrink the scan first: a count change inside a committing write keeps data invalid.
        wr(VIDS_OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            wr(VIDS_OFS_CHCFG, 32'(i));
            repeat (2) @(posedge core_clk);
            chk(32'(status_image[2]), 32'h1);
            wr(VIDS_OFS_CTRL, 32'h0000_0101);
            wait_conv(2);
            chk(32'(status_image[2]), 32'h0);
            chk(32'(conv_chan), 32'h0);
            chk(32'(conv_range), 32'(i % 4));
            rchk(VIDS_OFS_CHCFG, {w_t[i], 16'(i)});
            rchk(VIDS_OFS_RAW, {16'h0, r_t[i]});
            rchk(VIDS_OFS_SCALED, {(i == 2 || i == 3) ? 16'hFFFF : 16'h0, r_t[i]});
        end
        wr(VIDS_OFS_WMIN, 32'h0000_11F8);
        wr(VIDS_OFS_WMAX, 32'h0000_120C);
        wr(VIDS_OFS_RMIN, 32'h0);
        wr(VIDS_OFS_RMAX, 32'h0000_0014);
        wr(VIDS_OFS_CHCFG, 32'h0000_000C);
        wait_conv(2);
        rchk(VIDS_OFS_SCALED, 32'h0000_003C);
        wr(VIDS_OFS_CHCFG, 32'h0000_001C);
        wait_conv(2);
        rchk(VIDS_OFS_SCALED, 32'h0000_0014);
        wr(VIDS_OFS_IRQ_CLR, 32'h0000_000F);
        wr(VIDS_OFS_IRQ_EN, 32'h0000_0002);
        supply_ok <= 1'b0;
        selftest_ok <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk(32'(status_image[1:0]), 32'h3);
        chk(32'(irq), 32'h1);
        supply_ok <= 1'b1;
        selftest_ok <= 1'b1;
        // Scans keep completing meanwhile, so the scan bit is set as well.
        rchk(VIDS_OFS_IRQ_STAT, 32'h0000_000B);
        chk(32'(status_image[1:0]), 32'h0);
        wr(VIDS_OFS_IRQ_EN, 32'h0);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        wr(VIDS_OFS_IRQ_EN, 32'h0000_0002);
        @(posedge core_clk);
        chk(32'(irq), 32'h1);
        wr(VIDS_OFS_IRQ_CLR, 32'h0000_0002);
        @(posedge core_clk);
        chk(32'(irq), 32'h0);
        over_req <= 1'b1;
        wait_conv(2);
        chk(32'(status_image[8]), 32'h1);
        rchk(VIDS_OFS_IRQ_STAT, 32'h0000_000D);
        over_req <= 1'b0;
        wait_conv(2);
        chk(32'(status_image[8]), 32'h0);
        wr(VIDS_OFS_CTRL, 32'h0000_0100);
        over_chan <= 4'h8;
        over_req <= 1'b1;
        slow <= 1'b1;
        wait_conv(20);
        chk(32'(status_image[23:8]), 32'h0000_0100);
        chk(32'(status_image[2]), 32'h1);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
